// *** core/idp_device_port.sv ***
// ieee 488 instrument-side bus port: handshakes, addressing, remote/local, polls
`timescale 1ns/1ps
module idp_device_port import idp_pkg::*; (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	// bus data lines, low true, open drain
	input wire logic [7:0] DIO_N_I,
	output logic [7:0] DIO_N_O,
	output logic [7:0] DIO_N_OE,
	// bus management and handshake lines
	input wire logic ATN_N_I,
	input wire logic IFC_N_I,
	input wire logic REN_N_I,
	input wire logic EOI_N_I,
	output logic EOI_N_O,
	output logic EOI_N_OE,
	input wire logic DAV_N_I,
	output logic DAV_N_O,
	output logic DAV_N_OE,
	input wire logic NRFD_N_I,
	output logic NRFD_N_O,
	output logic NRFD_N_OE,
	input wire logic NDAC_N_I,
	output logic NDAC_N_O,
	output logic NDAC_N_OE,
	output logic SRQ_N_O,
	output logic SRQ_N_OE,
	// address setting
	input wire logic [5:0] ADDR_SEL,
	input wire logic ADDR_SAVE,
	// talker data
	input wire logic [7:0] TX_DATA,
	input wire logic TX_EOI,
	input wire logic TX_VALID,
	output logic TX_READY,
	// listener data
	output logic [7:0] RX_DATA,
	output logic RX_EOI,
	output logic RX_VALID,
	// status
	input wire logic OP_DONE,
	input wire logic STB_CLEAR,
	input wire logic [7:0] ESR_SET,
	input wire logic ESR_CLEAR,
	input wire logic SRE_LOAD,
	input wire logic [7:0] SRE_VALUE,
	input wire logic ESE_LOAD,
	input wire logic [7:0] ESE_VALUE,
	output logic [7:0] ESR,
	output logic [7:0] STB,
	// instrument control
	input wire logic LOCAL_KEY,
	output logic REMOTE,
	output logic LOCKOUT,
	output logic DEV_CLEAR,
	output logic TRIGGER,
	output logic TALK_ACT,
	output logic LISTEN_ACT
);
	idp_lines_t pins_raw, sync1_r, bus;
	idp_state_t st_r, st_nxt;
	logic [6:0] cmd;
	logic lon, ton, talk_act, listen_act, ah_act, take_cmd, ppoll, esb, svc, tx_ready;
	logic [7:0] stb_core, stb_byte, pp_drive;

	// own address with a listen or talk command in bits 6:5
	function automatic logic addr_hit(input logic [6:0] c, input logic [1:0] g, input logic [5:0] a);
		return c[6:5] == g && {1'b0, c[4:0]} == a && a <= ADDR_MAX;
	endfunction

	//------------------------------------------------------------
	// pin synchroniser
	//------------------------------------------------------------
	// invert the low true pins so that 1 means asserted inside
	assign pins_raw = {~ATN_N_I, ~EOI_N_I, ~IFC_N_I, ~REN_N_I, ~DAV_N_I, ~NRFD_N_I, ~NDAC_N_I, ~DIO_N_I};

	// two stages; only bus is read by the logic
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			sync1_r <= '0;
			bus <= '0;
		end else begin
			sync1_r <= pins_raw;
			bus <= sync1_r;
		end
	end

	//------------------------------------------------------------
	// decode helpers
	//------------------------------------------------------------
	assign cmd = bus.dio[6:0];
	assign lon = st_r.addr == ADDR_LISTEN_ONLY;
	assign ton = st_r.addr == ADDR_TALK_ONLY;
	assign talk_act = (st_r.tad | ton) & ~bus.atn;
	assign listen_act = st_r.lad | lon;
	// the acceptor joins every byte under attention and data when listening
	assign ah_act = bus.atn | listen_act;
	assign take_cmd = st_r.ah == AH_READY && ah_act && bus.dav && bus.atn;
	assign ppoll = bus.atn & bus.eoi;
	assign esb = |(st_r.esr & st_r.ese);
	assign stb_core = (8'(st_r.done) << STB_DONE_BIT) | (8'(esb) << STB_ESB_BIT);
	assign stb_byte = stb_core | (8'(st_r.rqs) << STB_RQS_BIT);
	assign svc = |(stb_core & st_r.sre);
	// serial poll has priority over user data while talking
	assign tx_ready = talk_act && !st_r.spe && st_r.sh == SH_IDLE;
	// poll bit follows the same completion flag as the status byte
	assign pp_drive = (ppoll && st_r.pp_en && st_r.done == st_r.pp_sense) ? 8'h01 << st_r.pp_line : 8'h00;

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rx_valid = 1'b0;
		st_nxt.devclr = 1'b0;
		st_nxt.trig = 1'b0;
		// invalid settings are dropped so the address stays usable
		if (ADDR_SAVE && (ADDR_SEL <= ADDR_MAX || ADDR_SEL == ADDR_LISTEN_ONLY || ADDR_SEL == ADDR_TALK_ONLY)) begin
			st_nxt.addr = ADDR_SEL;
		end
		// acceptor handshake
		case (st_r.ah)
			AH_IDLE: begin
				if (ah_act) begin
					st_nxt.ah = AH_READY;
				end
			end
			AH_READY: begin
				if (!ah_act) begin
					st_nxt.ah = AH_IDLE;
				end else if (bus.dav) begin
					st_nxt.ah = AH_ACCEPT;
					if (bus.atn) begin
						if (cmd[6:5] != GRP_SEC) begin
							st_nxt.ppc = 1'b0;
						end
						if (addr_hit(cmd, GRP_LAG, st_r.addr)) begin
							st_nxt.lad = 1'b1;
							st_nxt.tad = 1'b0;
							st_nxt.remote = st_r.remote | bus.ren;
						end else if (cmd == CMD_UNL) begin
							st_nxt.lad = 1'b0;
						end
						// other talk addresses and untalk all drop the talker
						if (addr_hit(cmd, GRP_TAG, st_r.addr)) begin
							st_nxt.tad = 1'b1;
							st_nxt.lad = 1'b0;
						end else if (cmd[6:5] == GRP_TAG) begin
							st_nxt.tad = 1'b0;
						end
						if (cmd[6:5] == GRP_SEC && st_r.ppc && st_r.lad) begin
							st_nxt.pp_en = ~cmd[PPE_OFF_BIT];
							st_nxt.pp_sense = cmd[PPE_SENSE_BIT];
							st_nxt.pp_line = cmd[2:0];
						end
						case (cmd)
							CMD_GTL: begin
								if (st_r.lad) begin
									st_nxt.remote = 1'b0;
									st_nxt.lockout = 1'b0;
								end
							end
							CMD_SDC: st_nxt.devclr = st_r.lad;
							CMD_DCL: st_nxt.devclr = 1'b1;
							CMD_PPC: st_nxt.ppc = st_r.lad;
							CMD_GET: st_nxt.trig = st_r.lad;
							CMD_LLO: begin
								st_nxt.lockout = 1'b1;
								st_nxt.remote = 1'b1;
							end
							CMD_PPU: st_nxt.pp_en = 1'b0;
							CMD_SPE: st_nxt.spe = 1'b1;
							CMD_SPD: st_nxt.spe = 1'b0;
							default: ;
						endcase
					end else begin
						st_nxt.rx_data = bus.dio;
						st_nxt.rx_eoi = bus.eoi;
						st_nxt.rx_valid = 1'b1;
					end
				end
			end
			AH_ACCEPT: begin
				if (!bus.dav) begin
					st_nxt.ah = ah_act ? AH_READY : AH_IDLE;
				end
			end
			default: st_nxt.ah = AH_IDLE;
		endcase
		// source handshake; data settles before dav is asserted
		case (st_r.sh)
			SH_IDLE: begin
				if (talk_act && st_r.spe) begin
					st_nxt.tx_byte = stb_byte;
					st_nxt.tx_eoi = 1'b0;
					st_nxt.tx_stb = 1'b1;
					st_nxt.sh = SH_SETTLE;
					st_nxt.cnt = '0;
				end else if (tx_ready && TX_VALID) begin
					st_nxt.tx_byte = TX_DATA;
					st_nxt.tx_eoi = TX_EOI;
					st_nxt.tx_stb = 1'b0;
					st_nxt.sh = SH_SETTLE;
					st_nxt.cnt = '0;
				end
			end
			SH_SETTLE: begin
				if (st_r.cnt != SETTLE_LAST) begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end else if (!bus.nrfd) begin
					st_nxt.sh = SH_DAV;
				end
			end
			SH_DAV: begin
				if (!bus.ndac) begin
					st_nxt.sh = SH_IDLE;
				end
			end
			default: st_nxt.sh = SH_IDLE;
		endcase
		// attention or loss of talker role aborts a byte in flight
		if (!talk_act) begin
			st_nxt.sh = SH_IDLE;
		end
		// status; a setting event wins over a clear in the same cycle
		if (STB_CLEAR) begin
			st_nxt.done = 1'b0;
		end
		if (OP_DONE) begin
			st_nxt.done = 1'b1;
		end
		st_nxt.esr = (ESR_CLEAR ? 8'h00 : st_r.esr) | ESR_SET;
		if (SRE_LOAD) begin
			st_nxt.sre = SRE_VALUE;
		end
		if (ESE_LOAD) begin
			st_nxt.ese = ESE_VALUE;
		end
		// request service on a new cause; a polled status byte withdraws it
		st_nxt.svc_q = svc;
		if (!svc) begin
			st_nxt.rqs = 1'b0;
		end else if (!st_r.svc_q) begin
			st_nxt.rqs = 1'b1;
		end else if (st_r.sh == SH_DAV && !bus.ndac && st_r.tx_stb) begin
			st_nxt.rqs = 1'b0;
		end
		// clears, in rising priority
		if (st_nxt.devclr) begin
			st_nxt.spe = 1'b0;
			st_nxt.ppc = 1'b0;
			st_nxt.sh = SH_IDLE;
		end
		if (bus.ifc) begin
			st_nxt.lad = 1'b0;
			st_nxt.tad = 1'b0;
			st_nxt.spe = 1'b0;
			st_nxt.ppc = 1'b0;
			st_nxt.sh = SH_IDLE;
		end
		if (LOCAL_KEY && !st_r.lockout) begin
			st_nxt.remote = 1'b0;
		end
		if (!bus.ren) begin
			st_nxt.remote = 1'b0;
			st_nxt.lockout = 1'b0;
		end
	end

	// power-on state: local, unaddressed, masks clear, no poll line
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	// open drain: the level is always low, only enables vary
	assign DIO_N_O = 8'h00;
	assign EOI_N_O = 1'b0;
	assign DAV_N_O = 1'b0;
	assign NRFD_N_O = 1'b0;
	assign NDAC_N_O = 1'b0;
	assign SRQ_N_O = 1'b0;
	assign DIO_N_OE = (st_r.sh != SH_IDLE ? st_r.tx_byte : 8'h00) | pp_drive;
	assign EOI_N_OE = st_r.sh != SH_IDLE && st_r.tx_eoi;
	assign DAV_N_OE = st_r.sh == SH_DAV;
	assign NRFD_N_OE = st_r.ah == AH_ACCEPT;
	assign NDAC_N_OE = st_r.ah == AH_READY;
	assign SRQ_N_OE = st_r.rqs;
	assign TX_READY = tx_ready;
	assign RX_DATA = st_r.rx_data;
	assign RX_EOI = st_r.rx_eoi;
	assign RX_VALID = st_r.rx_valid;
	assign ESR = st_r.esr;
	assign STB = stb_byte;
	assign REMOTE = st_r.remote;
	assign LOCKOUT = st_r.lockout;
	assign DEV_CLEAR = st_r.devclr;
	assign TRIGGER = st_r.trig;
	assign TALK_ACT = st_r.tad | ton;
	assign LISTEN_ACT = listen_act;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	property p_ah_accept; st_r.ah == AH_READY && ah_act && bus.dav |=> NRFD_N_OE && !NDAC_N_OE; endproperty
	a_ah_accept: assert property (p_ah_accept) else $error("acceptor did not take byte");
	property p_sh_release; st_r.sh == SH_DAV && !bus.ndac |=> !DAV_N_OE; endproperty
	a_sh_release: assert property (p_sh_release) else $error("dav held after accept");
	property p_mla; take_cmd && addr_hit(cmd, GRP_LAG, st_r.addr) && !bus.ifc |=> st_r.lad && !st_r.tad; endproperty
	a_mla: assert property (p_mla) else $error("listen address left talker on");
	property p_mta; take_cmd && addr_hit(cmd, GRP_TAG, st_r.addr) && !bus.ifc |=> st_r.tad && !st_r.lad; endproperty
	a_mta: assert property (p_mta) else $error("talk address left listener on");
	property p_addr; ADDR_SAVE && ADDR_SEL <= ADDR_MAX |=> st_r.addr == $past(ADDR_SEL); endproperty
	a_addr: assert property (p_addr) else $error("address not taken");
	property p_addr_hold; st_r.addr != $past(st_r.addr) |-> $past(ADDR_SAVE); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed without save");
	property p_lon; lon && !bus.atn && st_r.ah == AH_READY && bus.dav |=> RX_VALID; endproperty
	a_lon: assert property (p_lon) else $error("listen only missed data");
	property p_ton; ton && !bus.atn && !bus.ifc && !st_r.spe && st_r.sh == SH_IDLE && TX_VALID |=> st_r.sh == SH_SETTLE; endproperty
	a_ton: assert property (p_ton) else $error("talk only did not send");
	property p_dcl; take_cmd && cmd == CMD_DCL |=> DEV_CLEAR && !st_r.spe ##1 !DEV_CLEAR; endproperty
	a_dcl: assert property (p_dcl) else $error("device clear not one pulse");
	property p_ifc; bus.ifc |=> !TALK_ACT || ton ##0 !st_r.lad && !st_r.spe; endproperty
	a_ifc: assert property (p_ifc) else $error("still addressed after ifc");
	property p_gtl; take_cmd && cmd == CMD_GTL && st_r.lad |=> !REMOTE && !LOCKOUT; endproperty
	a_gtl: assert property (p_gtl) else $error("go to local ignored");
	property p_lock; LOCKOUT && REMOTE && bus.ren && LOCAL_KEY && !take_cmd |=> REMOTE; endproperty
	a_lock: assert property (p_lock) else $error("local key worked in lockout");
	property p_ren; !bus.ren |=> !REMOTE && !LOCKOUT; endproperty
	a_ren: assert property (p_ren) else $error("remote kept without enable");
	property p_spoll; talk_act && st_r.spe && st_r.sh == SH_IDLE |=> st_r.tx_stb && st_r.tx_byte == $past(stb_byte); endproperty
	a_spoll: assert property (p_spoll) else $error("wrong serial poll byte");
	property p_por; disable iff (1'b0) $past(SYS_RST) |-> !REMOTE && !TALK_ACT && !LISTEN_ACT && ESR == ESR_RESET && STB == 8'h00; endproperty
	a_por: assert property (p_por) else $error("bad power-on state");
	property p_por_pp; disable iff (1'b0) $past(SYS_RST) |-> !st_r.pp_en && DIO_N_OE == 8'h00; endproperty
	a_por_pp: assert property (p_por_pp) else $error("poll line assigned at power-on");
	property p_pp_only; !ppoll && st_r.sh == SH_IDLE |-> DIO_N_OE == 8'h00; endproperty
	a_pp_only: assert property (p_pp_only) else $error("data lines driven outside poll");
endmodule

// *** core/idp_pkg.sv ***
// constants, types and reset state for the ieee 488 device port
//------------------------------------------------------------
//------------------------------------------------------------
package idp_pkg;
	// timing
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = $clog2(SETTLE_CYC);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
	// address settings
	localparam logic [5:0] ADDR_DEFAULT = 6'h0D;
	localparam logic [5:0] ADDR_MAX = 6'h1E;
	localparam logic [5:0] ADDR_LISTEN_ONLY = 6'h28;
	localparam logic [5:0] ADDR_TALK_ONLY = 6'h32;
	// command groups in bits 6:5 of a byte sent under attention
	localparam logic [1:0] GRP_LAG = 2'h1;
	localparam logic [1:0] GRP_TAG = 2'h2;
	localparam logic [1:0] GRP_SEC = 2'h3;
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_PPC = 7'h05;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_PPU = 7'h15;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam int PPE_SENSE_BIT = 3;
	localparam int PPE_OFF_BIT = 4;
	// status byte layout
	localparam int STB_DONE_BIT = 0;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;
	localparam logic [7:0] ESR_RESET = 8'h80;
	// bus lines, 1 = asserted (pins are low true)
	typedef struct packed {
		logic atn;
		logic eoi;
		logic ifc;
		logic ren;
		logic dav;
		logic nrfd;
		logic ndac;
		logic [7:0] dio;
	} idp_lines_t;
	typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_ACCEPT} idp_ah_t;
	typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV} idp_sh_t;
	typedef struct packed {
		idp_ah_t ah;
		idp_sh_t sh;
		logic [CNT_W-1:0] cnt;
		logic [5:0] addr;
		logic lad;
		logic tad;
		logic spe;
		logic ppc;
		logic pp_en;
		logic pp_sense;
		logic [2:0] pp_line;
		logic remote;
		logic lockout;
		logic done;
		logic rqs;
		logic svc_q;
		logic [7:0] esr;
		logic [7:0] sre;
		logic [7:0] ese;
		logic [7:0] tx_byte;
		logic tx_eoi;
		logic tx_stb;
		logic [7:0] rx_data;
		logic rx_eoi;
		logic rx_valid;
		logic devclr;
		logic trig;
	} idp_state_t;
	localparam idp_state_t ST_RESET = '{ah: AH_IDLE, sh: SH_IDLE, addr: ADDR_DEFAULT, esr: ESR_RESET, default: '0};
endpackage

// *** test/idp_ctrl_model.sv ***
// bus controller model: sends commands and data, listens to the talker, runs polls
`timescale 1ns/1ps
module idp_ctrl_model import idp_pkg::*; (
	// clock
	input wire logic clk,
	// resolved bus, 1 = asserted
	input wire idp_lines_t bus,
	// lines this controller pulls, 1 = asserted
	output idp_lines_t drv
);
	// nothing pulled at power-up; released lines sit at the pull-up level
	initial drv = '0;

	//------------------------------------------------------------
	// handshakes
	//------------------------------------------------------------
	// one byte out, e marks the last one; waits are bounded so a dead port cannot hang the run
	task automatic send(input logic [7:0] b, input logic atn, input logic e = 1'b0);
		int k;
		@(posedge clk);
		drv.nrfd <= 1'b0;
		drv.ndac <= 1'b0;
		drv.atn <= atn;
		drv.eoi <= e;
		drv.dio <= b;
		// listeners need a few edges to see attention change, drop a talker and get ready
		repeat (3) @(posedge clk);
		k = 0;
		do begin @(posedge clk); k++; end while (bus.nrfd && k < 400);
		drv.dav <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (bus.ndac && k < 400);
		drv.dav <= 1'b0;
		drv.eoi <= 1'b0;
		drv.dio <= 8'h00; // freed lines float back to the pull-up
		repeat (4) @(posedge clk);
	endtask

	// one byte in; wt holds off ready to act as a slow listener
	task automatic recv(input int wt, output logic [7:0] b, output logic e);
		int k;
		@(posedge clk);
		drv.atn <= 1'b0;
		drv.ndac <= 1'b1;
		drv.nrfd <= 1'b1;
		repeat (wt + 1) @(posedge clk);
		drv.nrfd <= 1'b0;
		k = 0;
		do begin @(posedge clk); k++; end while (!bus.dav && k < 400);
		b = bus.dio;
		e = bus.eoi;
		drv.nrfd <= 1'b1;
		drv.ndac <= 1'b0;
		k = 0;
		do begin @(posedge clk); k++; end while (bus.dav && k < 400);
		drv.ndac <= 1'b1;
	endtask

	// parallel poll: attention with end, then read the data lines
	task automatic ppoll(output logic [7:0] b);
		@(posedge clk);
		drv.atn <= 1'b1;
		drv.eoi <= 1'b1;
		repeat (4) @(posedge clk);
		b = bus.dio;
		drv.eoi <= 1'b0;
		@(posedge clk);
	endtask

	// interface clear pulse
	task automatic ifc_pulse();
		@(posedge clk);
		drv.ifc <= 1'b1;
		repeat (4) @(posedge clk);
		drv.ifc <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// remote enable level, given time to pass the synchroniser
	task automatic set_ren(input logic v);
		@(posedge clk);
		drv.ren <= v;
		repeat (3) @(posedge clk);
	endtask
endmodule

// *** test/tb_ieee488_device_port.sv ***
// self-checking bench for the ieee 488 device port against a controller model
`timescale 1ns/1ps
module tb_ieee488_device_port import idp_pkg::*;;
	logic clk, sys_rst, addr_save, tx_eoi, tx_valid, op_done, stb_clear, esr_clear, sre_load, ese_load, local_key;
	logic [5:0] addr_sel;
	logic [7:0] tx_data, esr_set, sre_value, ese_value, rx_data, esr, stb, dio_oe, rx_last;
	logic eoi_oe, dav_oe, nrfd_oe, ndac_oe, srq_oe, tx_ready, rx_eoi, rx_valid;
	logic remote, lockout, dev_clear, trigger, talk_act, listen_act;
	idp_lines_t drv, bus;
	int n_mismatch, n_checks, n_clr, n_trig, n_rx;

	// open-drain wired-or: a line is asserted if any party pulls it
	assign bus = '{atn: drv.atn, eoi: drv.eoi | eoi_oe, ifc: drv.ifc, ren: drv.ren, dav: drv.dav | dav_oe,
		nrfd: drv.nrfd | nrfd_oe, ndac: drv.ndac | ndac_oe, dio: drv.dio | dio_oe};

	idp_ctrl_model u_ctl (.clk(clk), .bus(bus), .drv(drv));

	idp_device_port u_dut (.REF_CLK(clk), .SYS_RST(sys_rst), .DIO_N_I(~bus.dio), .DIO_N_O(), .DIO_N_OE(dio_oe),
		.ATN_N_I(~bus.atn), .IFC_N_I(~bus.ifc), .REN_N_I(~bus.ren), .EOI_N_I(~bus.eoi), .EOI_N_O(),
		.EOI_N_OE(eoi_oe), .DAV_N_I(~bus.dav), .DAV_N_O(), .DAV_N_OE(dav_oe), .NRFD_N_I(~bus.nrfd),
		.NRFD_N_O(), .NRFD_N_OE(nrfd_oe), .NDAC_N_I(~bus.ndac), .NDAC_N_O(), .NDAC_N_OE(ndac_oe),
		.SRQ_N_O(), .SRQ_N_OE(srq_oe), .ADDR_SEL(addr_sel), .ADDR_SAVE(addr_save), .TX_DATA(tx_data),
		.TX_EOI(tx_eoi), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_EOI(rx_eoi),
		.RX_VALID(rx_valid), .OP_DONE(op_done), .STB_CLEAR(stb_clear), .ESR_SET(esr_set),
		.ESR_CLEAR(esr_clear), .SRE_LOAD(sre_load), .SRE_VALUE(sre_value), .ESE_LOAD(ese_load),
		.ESE_VALUE(ese_value), .ESR(esr), .STB(stb), .LOCAL_KEY(local_key), .REMOTE(remote),
		.LOCKOUT(lockout), .DEV_CLEAR(dev_clear), .TRIGGER(trigger), .TALK_ACT(talk_act),
		.LISTEN_ACT(listen_act));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// pulse counters; pulses last one cycle so they are caught at the edge
	always @(posedge clk) begin
		if (dev_clear === 1'b1) n_clr++;
		if (trigger === 1'b1) n_trig++;
		if (rx_valid === 1'b1) begin
			n_rx++;
			rx_last = rx_data;
		end
	end

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// let edges pass, then sample settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// save a new address setting
	task automatic set_addr(input logic [5:0] v);
		@(posedge clk);
		addr_sel <= v;
		addr_save <= 1'b1;
		@(posedge clk);
		addr_save <= 1'b0;
		wt(2);
	endtask

	// offer one talker byte, held until taken
	task automatic put(input logic [7:0] d, input logic e);
		int k;
		@(posedge clk);
		tx_data <= d;
		tx_eoi <= e;
		tx_valid <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (tx_ready !== 1'b1 && k < 400);
		tx_valid <= 1'b0;
	endtask

	// front panel local key
	task automatic key();
		@(posedge clk);
		local_key <= 1'b1;
		@(posedge clk);
		local_key <= 1'b0;
		wt(2);
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_power_on();
		logic [7:0] b;
		chk({remote, lockout, talk_act, listen_act, tx_ready, srq_oe, dav_oe, nrfd_oe}, 8'h00);
		chk(esr, 8'h80);
		chk(stb, 8'h00);
		u_ctl.ppoll(b);
		chk(b, 8'h00);
	endtask

	task automatic t_addressing();
		int n;
		u_ctl.set_ren(1'b1);
		u_ctl.send(8'h2D, 1'b1);
		wt(1);
		chk({6'h0, remote, listen_act}, 8'h03);
		key();
		chk({7'h0, remote}, 8'h00);
		n = n_rx;
		u_ctl.send(8'h5A, 1'b0);
		chk(rx_last, 8'h5A);
		u_ctl.send(8'h3F, 1'b1);
		u_ctl.send(8'hC3, 1'b0); // not a listener now: must be ignored
		chk(8'(n_rx - n), 8'h01);
		u_ctl.send(8'h2D, 1'b1);
		u_ctl.send(8'h4D, 1'b1);
		wt(1);
		chk({6'h0, talk_act, listen_act}, 8'h02);
		u_ctl.send(8'h2D, 1'b1);
		wt(1);
		chk({6'h0, talk_act, listen_act}, 8'h01);
		u_ctl.send(8'h3F, 1'b1);
	endtask

	task automatic t_talk();
		logic [7:0] b;
		logic e;
		u_ctl.send(8'h4D, 1'b1);
		fork
			put(8'hA5, 1'b1);
			u_ctl.recv(0, b, e);
		join
		chk(b, 8'hA5);
		chk({7'h0, e}, 8'h01);
		fork
			put(8'h3C, 1'b0);
			u_ctl.recv(40, b, e);
		join
		chk({b[6:0], e}, 8'h78);
		u_ctl.send(8'h5F, 1'b1);
	endtask

	task automatic t_address_setting();
		logic [7:0] b;
		logic e;
		logic [5:0] v [2] = '{6'h00, 6'h1E};
		foreach (v[i]) begin
			set_addr(v[i]);
			u_ctl.send(8'h2D, 1'b1);
			wt(1);
			chk({7'h0, listen_act}, 8'h00);
			u_ctl.send({3'h1, v[i][4:0]}, 1'b1);
			wt(1);
			chk({7'h0, listen_act}, 8'h01);
			u_ctl.send(8'h3F, 1'b1);
		end
		set_addr(6'h28);
		chk({6'h0, talk_act, listen_act}, 8'h01);
		u_ctl.send(8'h77, 1'b0, 1'b1);
		chk(rx_last, 8'h77);
		chk({7'h0, rx_eoi}, 8'h01);
		set_addr(6'h32);
		chk({6'h0, talk_act, listen_act}, 8'h02);
		fork
			put(8'h96, 1'b0);
			u_ctl.recv(0, b, e);
		join
		chk(b, 8'h96);
		set_addr(6'h0D);
	endtask

	task automatic t_clears();
		int n;
		int t;
		u_ctl.send(8'h2D, 1'b1);
		n = n_clr;
		u_ctl.send(8'h04, 1'b1);
		u_ctl.send(8'h14, 1'b1);
		chk(8'(n_clr - n), 8'h02);
		t = n_trig;
		u_ctl.send(8'h08, 1'b1);
		chk(8'(n_trig - t), 8'h01);
		n = n_clr;
		u_ctl.ifc_pulse();
		wt(1);
		chk({6'h0, talk_act, listen_act}, 8'h00);
		chk(8'(n_clr - n), 8'h00);
	endtask

	task automatic t_lockout();
		u_ctl.send(8'h2D, 1'b1);
		u_ctl.send(8'h11, 1'b1);
		wt(1);
		chk({6'h0, remote, lockout}, 8'h03);
		key();
		chk({6'h0, remote, lockout}, 8'h03);
		u_ctl.send(8'h01, 1'b1);
		wt(1);
		chk({6'h0, remote, lockout}, 8'h00);
		u_ctl.send(8'h11, 1'b1);
		u_ctl.set_ren(1'b0); // cable pulled
		wt(1);
		chk({6'h0, remote, lockout}, 8'h00);
		u_ctl.set_ren(1'b1);
		u_ctl.send(8'h3F, 1'b1);
	endtask

	task automatic t_polls();
		logic [7:0] b;
		logic e;
		@(posedge clk);
		sre_value <= 8'h01;
		sre_load <= 1'b1;
		ese_value <= 8'h04;
		ese_load <= 1'b1;
		esr_set <= 8'h04;
		op_done <= 1'b1;
		@(posedge clk);
		sre_load <= 1'b0;
		ese_load <= 1'b0;
		esr_set <= 8'h00;
		op_done <= 1'b0;
		wt(3);
		chk(esr, 8'h84);
		chk(stb, 8'h61);
		chk({7'h0, srq_oe}, 8'h01);
		u_ctl.send(8'h18, 1'b1);
		u_ctl.send(8'h4D, 1'b1);
		u_ctl.recv(0, b, e);
		chk(b, 8'h61);
		wt(2);
		chk({7'h0, srq_oe}, 8'h00);
		u_ctl.send(8'h19, 1'b1);
		u_ctl.send(8'h5F, 1'b1);
		chk(stb, 8'h21);
		u_ctl.send(8'h2D, 1'b1);
		u_ctl.send(8'h05, 1'b1);
		u_ctl.send(8'h6A, 1'b1);
		u_ctl.send(8'h3F, 1'b1);
		u_ctl.ppoll(b);
		chk(b, 8'h04);
		@(posedge clk);
		stb_clear <= 1'b1;
		esr_clear <= 1'b1;
		@(posedge clk);
		stb_clear <= 1'b0;
		esr_clear <= 1'b0;
		wt(2);
		chk(esr, 8'h00);
		u_ctl.ppoll(b);
		chk(b, 8'h00);
	endtask

	// main sequence; inputs all defined at time zero
	initial begin
		sys_rst = 1'b1;
		{addr_save, tx_eoi, tx_valid, op_done, stb_clear, esr_clear, sre_load, ese_load, local_key} = '0;
		{addr_sel, tx_data, esr_set, sre_value, ese_value} = '0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		wt(3);
		t_power_on();
		t_addressing();
		t_talk();
		t_address_setting();
		t_clears();
		t_lockout();
		t_polls();
		print_verdict();
	end

	// watchdog, well beyond the thousand or so cycles the run needs
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
endmodule
